// file: src/pcei_pkg.sv
// Package for the pin change edge interrupt block
// Notes on behaviour
// - With the master enable set, a change interrupt wakes the core.
// - An edge seen in sleep is in the flags before the first instruction.
// - Rising enable bits 5..0 arm rising detection on their pins.
// - Falling enable bits 5..0 arm falling detection on their pins.
// - A rising edge on a rising-enabled pin sets that pin's flag.
// - A falling edge on a falling-enabled pin sets it; both mean any edge.
// - Flags stay set until software writes them to zero.
// - Flags are read/write registers that hardware may also set.
// - Bits 7 and 6 of the three registers read as zero.
// - With the master enable clear, flags still set but no interrupt rises.
// - The summary bit is the OR of the six flags.
// - An edge during a flag write leaves its flag set whatever is written.
package pcei_pkg;
    localparam int PCEI_NPINS = 6;
    localparam int PCEI_AW = 4;
    localparam logic [3:0] PCEI_OFS_RISE = 4'h0;
    localparam logic [3:0] PCEI_OFS_FALL = 4'h4;
    localparam logic [3:0] PCEI_OFS_FLAG = 4'h8;
    localparam logic [3:0] PCEI_OFS_CTRL = 4'hC;
    localparam int PCEI_CTRL_IE_BIT = 0;
    localparam int PCEI_CTRL_SUM_BIT = 1;
    localparam logic [5:0] PCEI_RST_EN = 6'h00;
    localparam logic [5:0] PCEI_RST_FLAG = 6'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } pcei_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pcei_wb_rsp_type;
endpackage

// file: src/pcei_sync.sv
// Two-stage pin synchroniser with previous-sample stage
`timescale 1ns/1ns
module pcei_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Pins
    input wire logic [5:0] pin_i,
    // Synchronised samples
    output logic [5:0] cur_o,
    output logic [5:0] prev_o
);
    import pcei_pkg::*;
    logic [5:0] s1_r, s2_r, s3_r;
    logic [5:0] s1_nxt, s2_nxt, s3_nxt;
    always_comb begin
        s1_nxt = pin_i;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end
    // Reset to zero so an input held high reads as a rising edge
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s1_r <= 6'h00;
            s2_r <= 6'h00;
            s3_r <= 6'h00;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end
    assign cur_o = s2_r;
    assign prev_o = s3_r;
endmodule

// file: src/pcei_top.sv
// Pin change edge detector with Wishbone registers
`timescale 1ns/1ns
module pcei_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Port pins
    input wire logic [5:0] port_pin_i,
    // Wishbone slave
    input wire pcei_pkg::pcei_wb_req_type wb_req_i,
    output pcei_pkg::pcei_wb_rsp_type wb_rsp_o,
    // Interrupt and wake
    output logic change_irq_o,
    output logic wake_o
);
    import pcei_pkg::*;

    logic [5:0] cur, prev, rise_det, fall_det, hit;
    logic [5:0] rise_r, rise_nxt, fall_r, fall_nxt, flag_r, flag_nxt;
    logic ie_r, ie_nxt, ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic wr, rd_sel, summary;

    pcei_sync u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(port_pin_i),
        .cur_o(cur),
        .prev_o(prev)
    );

    // Per-pin detectors
    genvar g;
    generate
        for (g = 0; g < PCEI_NPINS; g++) begin : g_pin
            assign rise_det[g] = cur[g] & ~prev[g];
            assign fall_det[g] = ~cur[g] & prev[g];
            assign hit[g] = (rise_r[g] & rise_det[g])
                | (fall_r[g] & fall_det[g]);
        end
    endgenerate

    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_r
        & wb_req_i.sel[0];
    assign rd_sel = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
    assign summary = |flag_r;

    always_comb begin
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        flag_nxt = flag_r;
        ie_nxt = ie_r;
        if (wr) begin
            if (wb_req_i.adr == PCEI_OFS_RISE) begin
                rise_nxt = wb_req_i.dat[5:0];
            end else if (wb_req_i.adr == PCEI_OFS_FALL) begin
                fall_nxt = wb_req_i.dat[5:0];
            end else if (wb_req_i.adr == PCEI_OFS_FLAG) begin
                flag_nxt = wb_req_i.dat[5:0];
            end else if (wb_req_i.adr == PCEI_OFS_CTRL) begin
                ie_nxt = wb_req_i.dat[PCEI_CTRL_IE_BIT];
            end
        end
        // Set beats a clearing write in the same cycle
        flag_nxt = flag_nxt | hit;
    end

    always_comb begin
        ack_nxt = rd_sel;
        rdat_nxt = 32'h0000_0000;
        if (rd_sel) begin
            if (wb_req_i.adr == PCEI_OFS_RISE) begin
                rdat_nxt = {26'h0, rise_r};
            end else if (wb_req_i.adr == PCEI_OFS_FALL) begin
                rdat_nxt = {26'h0, fall_r};
            end else if (wb_req_i.adr == PCEI_OFS_FLAG) begin
                rdat_nxt = {26'h0, flag_r};
            end else if (wb_req_i.adr == PCEI_OFS_CTRL) begin
                rdat_nxt = {30'h0, summary, ie_r};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rise_r <= PCEI_RST_EN;
            fall_r <= PCEI_RST_EN;
            flag_r <= PCEI_RST_FLAG;
            ie_r <= 1'b0;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            flag_r <= flag_nxt;
            ie_r <= ie_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // Clock keeps running in sleep, so flags are current before wake
    assign change_irq_o = ie_r & summary;
    assign wake_o = ie_r & summary;
    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdat_r;

    // Assertions
    sequence rise_seen(int i);
        rise_r[i] && rise_det[i];
    endsequence
    rise_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rise_seen(0) |=> flag_r[0])
        else $error("rising edge did not set flag");
    fall_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (fall_r[1] && fall_det[1]) |=> flag_r[1])
        else $error("falling edge did not set flag");
    rise_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!rise_r[2] && !fall_r[2] && !flag_r[2] && !wr) |=> !flag_r[2])
        else $error("disarmed pin set flag");
    fall_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!fall_r[3] && fall_det[3] && !flag_r[3] && !wr) |=> !flag_r[3])
        else $error("falling disabled pin set flag");
    flag_sticky_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (flag_r[0] && !wr) |=> flag_r[0])
        else $error("flag dropped without write");
    set_wins_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (wr && hit[4]) |=> flag_r[4])
        else $error("edge lost during flag write");
    irq_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        change_irq_o == (ie_r && (flag_r != 6'h00)))
        else $error("interrupt not gated summary");
    wake_edge_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (ie_r && hit[5] && !(wr && wb_req_i.adr == PCEI_OFS_CTRL))
        |=> wake_o)
        else $error("no wake after edge");
    reset_clear_a: assert property (@(posedge mclk_i)
        ($past(sys_rst_i) && !sys_rst_i)
        |-> (rise_r == 6'h00 && fall_r == 6'h00 && flag_r == 6'h00))
        else $error("enables not cleared by reset");
    upper_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (ack_r && $past(wb_req_i.adr) != PCEI_OFS_CTRL)
        |-> rdat_r[7:6] == 2'b00)
        else $error("upper bits not zero");
endmodule

// file: tb/pcei_pins_model.sv
// Model of the outside signals on the six port pins
`timescale 1ns/1ns
module pcei_pins_model (
    // Clock
    input wire logic mclk_i,
    // Requested levels
    input wire logic [5:0] want_i,
    // Pins
    output logic [5:0] port_pin_o
);
    // Levels change just after an edge, as outside logic would
    always_ff @(posedge mclk_i) begin
        port_pin_o <= want_i;
    end
endmodule

// file: tb/pcei_top_tb_top.sv
// Testbench for the pin change edge interrupt block
`timescale 1ns/1ns
module pcei_top_tb_top;
    import pcei_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [5:0] want = 6'h00;
    logic [5:0] pins;
    pcei_wb_req_type req = '0;
    pcei_wb_rsp_type rsp;
    logic irq;
    logic wake;
    logic [31:0] q;
    int num_errors = 0;
    int total_checks = 0;
    pcei_pins_model i_pins (.mclk_i(mclk_i), .want_i(want),
        .port_pin_o(pins));
    pcei_top i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .port_pin_i(pins), .wb_req_i(req), .wb_rsp_o(rsp),
        .change_irq_o(irq), .wake_o(wake));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        req <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do begin
            @(posedge mclk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        q = rsp.dat;
        req <= '0;
        chk("ack", {31'h0, n < 50}, 32'h0000_0001);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk("read", q, e);
    endtask
    task automatic pin_set(input logic [5:0] v);
        @(posedge mclk_i);
        want <= v;
        repeat (8) @(posedge mclk_i);
    endtask
    task automatic test_reset;
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        rd(4'h8, 32'h0000_0000);
        rd(4'hC, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic test_edges;
        bus(1'b1, 4'h0, 32'hFFFF_FFFF);
        rd(4'h0, 32'h0000_003F);
        bus(1'b1, 4'h0, 32'h0000_0005);
        bus(1'b1, 4'h4, 32'h0000_000A);
        rd(4'h4, 32'h0000_000A);
        pin_set(6'h3F);
        rd(4'h8, 32'h0000_0005);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        rd(4'hC, 32'h0000_0002);
        pin_set(6'h00);
        rd(4'h8, 32'h0000_000F);
    endtask
    // Clear by masking only the bits known to be set
    task automatic test_clear;
        bus(1'b0, 4'h8, 32'h0000_0000);
        bus(1'b1, 4'h8, (32'h0000_00FF ^ 32'h0000_0001) & q);
        rd(4'h8, 32'h0000_000E);
        bus(1'b1, 4'h8, 32'h0000_0000);
        rd(4'h8, 32'h0000_0000);
    endtask
    task automatic test_wake;
        bus(1'b1, 4'hC, 32'h0000_0001);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        pin_set(6'h3F);
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        chk("wake", {31'h0, wake}, 32'h0000_0001);
        rd(4'h8, 32'h0000_0005);
        bus(1'b1, 4'h8, 32'h0000_0000);
        chk("wake", {31'h0, wake}, 32'h0000_0000);
    endtask
    // Disarmed pins, set beating a clearing write, gated interrupt
    task automatic test_more;
        bus(1'b1, 4'h0, 32'h0000_0010);
        bus(1'b1, 4'h4, 32'h0000_0020);
        pin_set(6'h00);
        rd(4'h8, 32'h0000_0020);
        chk("wake", {31'h0, wake}, 32'h0000_0001);
        bus(1'b1, 4'h8, 32'h0000_0000);
        @(posedge mclk_i);
        want <= 6'h10;
        repeat (2) @(posedge mclk_i);
        bus(1'b1, 4'h8, 32'h0000_0000);
        rd(4'h8, 32'h0000_0010);
        bus(1'b1, 4'hC, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        chk("wake", {31'h0, wake}, 32'h0000_0000);
        rd(4'hC, 32'h0000_0002);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        test_edges();
        test_clear();
        test_wake();
        test_more();
        summarize();
    end
    // Whole run needs under two hundred cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        num_errors++;
        summarize();
    end
endmodule
